// ---- oobf_consts.vh ----
// Constants for the output override and bus feedback register bank
`ifndef OOBF_CONSTS_VH
`define OOBF_CONSTS_VH

// ------------------------------------------------------------
// Parameter write addresses
// ------------------------------------------------------------
`define OOBF_ADDR_OVERRIDE 4'h0
`define OOBF_ADDR_AOUT1_LVL 4'h1
`define OOBF_ADDR_AOUT2_LVL 4'h2
`define OOBF_ADDR_FB_SEL1 4'h3
`define OOBF_ADDR_FB_SEL2 4'h4
`define OOBF_ADDR_FB_SEL3 4'h5
`define OOBF_ADDR_SETPT_FUNC1 4'h6

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define OOBF_OVERRIDE_RST 6'h00
`define OOBF_FB_SEL1_RST 4'h1
`define OOBF_FB_SEL23_RST 4'h0
`define OOBF_FB_SEL_MAX 4'hc
`define OOBF_AOUT_RST 10'h000
`define OOBF_AOUT_MAX 10'h064
`define OOBF_SETPT_FUNC_RST 3'h1
`define OOBF_FUNC_EXT_CTRL 3'h7

// ------------------------------------------------------------
// Override bit positions
// ------------------------------------------------------------
`define OOBF_BIT_RELAY1 0
`define OOBF_BIT_RELAY2 1
`define OOBF_BIT_AOUT1 2
`define OOBF_BIT_AOUT2 3
`define OOBF_BIT_RELAY3 4
`define OOBF_BIT_RELAY4 5

// ------------------------------------------------------------
// Feedback selector codes
// ------------------------------------------------------------
`define OOBF_SEL_OFF 4'h0
`define OOBF_SEL_OUT_FREQ 4'h1
`define OOBF_SEL_SPEED 4'h2
`define OOBF_SEL_CURRENT 4'h3
`define OOBF_SEL_TORQUE_CUR 4'h4
`define OOBF_SEL_DIG_IO 4'h5
`define OOBF_SEL_POS_ACT 4'h6
`define OOBF_SEL_POS_SET 4'h7
`define OOBF_SEL_NOM_FREQ 4'h8
`define OOBF_SEL_ERR_CODE 4'h9
`define OOBF_SEL_POS_INC_ACT 4'ha
`define OOBF_SEL_POS_INC_SET 4'hb
`define OOBF_SEL_BUS_OUT 4'hc

// Setpoint function codes that select a 32-bit position
`define OOBF_SETPT_POS32 3'h3
`define OOBF_SETPT_POS32_INC 3'h6

// Encoder resolution that increment feedback is scaled to
`define OOBF_INC_PER_REV 32'h0000_2000

`endif

// ---- oobf_output_override_bus_feedback.v ----
// Output override and bus actual value selection register bank
//
// Summary of operation
// RL1: Relays and digital outputs can be driven from an override word, ignoring drive state.
// RL2: Override bit acts only when output function is external control.
// RL3: Override word is 6 bits, any value 000000 to 111111 accepted.
// RL4: Bits 0..5 map to relay1, relay2, aout1 digital, aout2 digital, relay3, relay4.
// RL5: A written override value reaches outputs at once.
// RL6: Analog output can be forced 0.0 to 10.0 V, default 0.0, function code 7.
// RL7: Forced analog level reaches output only after entry is confirmed.
// RL8: Selector 0 to 12, default 1, chooses bus actual value 1.
// RL9: Codes 0..5: nothing, frequency, speed, current, torque current, digital IO.
// RL10: Codes 6..12: positions, nominal freq, error, increments, bus output bits.
// RL11: Digital IO word: inputs 1..12 in bits 0..11, relays 1..4 in 12..15.
// RL12: Position increments are scaled to an 8192 increment per revolution encoder.
// RL13: Increment width is 16 or 32 bits following setpoint position width.
// RL14: Out of range writes are rejected and the old value kept.
// RL15: Same selection scheme serves bus actual values 2 and 3.
`timescale 1ns/1ps
`include "oobf_consts.vh"

module oobf_output_override_bus_feedback (
    input wire clk, // 40 MHz system clock
    input wire rst_b, // Asynchronous reset, active low
    input wire par_wr, // Parameter write strobe, one cycle
    input wire [3:0] par_addr, // Parameter address
    input wire [31:0] par_wdata, // Parameter write data
    input wire par_confirm, // Analog level entry confirmed, one cycle
    input wire par_large_pdo, // Larger process data object type active
    input wire [2:0] func_relay1, // Relay 1 function selection
    input wire [2:0] func_relay2, // Relay 2 function selection
    input wire [2:0] func_relay3, // Relay 3 function selection
    input wire [2:0] func_relay4, // Relay 4 function selection
    input wire [2:0] func_aout1, // Analog output 1 function selection
    input wire [2:0] func_aout2, // Analog output 2 function selection
    input wire aout1_dig_mode, // Analog output 1 used digitally
    input wire aout2_dig_mode, // Analog output 2 used digitally
    input wire [3:0] norm_relay, // Relay states from normal functions
    input wire [1:0] norm_aout_dig, // Analog digital states from normal functions
    input wire [9:0] norm_aout1_lvl, // Normal analog 1 level, 0.1 V units
    input wire [9:0] norm_aout2_lvl, // Normal analog 2 level, 0.1 V units
    input wire [11:0] digital_input, // Digital inputs 1 to 12 (pins)
    input wire [15:0] q_out_freq, // Output frequency
    input wire [15:0] q_speed, // Speed
    input wire [15:0] q_current, // Current
    input wire [15:0] q_torque_cur, // Torque current
    input wire [31:0] q_pos_act, // Present position
    input wire [31:0] q_pos_set, // Set position
    input wire [15:0] q_nom_freq, // Nominal frequency
    input wire [15:0] q_err_code, // Error code
    input wire [31:0] q_pos_inc_act, // Present position, 8192 increments per rev
    input wire [31:0] q_pos_inc_set, // Set position, 8192 increments per rev
    input wire [15:0] q_bus_out, // Bus output bits
    output wire [3:0] relay_out, // Relay 1 to 4 drive
    output wire [1:0] aout_dig_out, // Analog outputs used digitally
    output wire [9:0] aout1_lvl, // Analog output 1 level, 0.1 V units
    output wire [9:0] aout2_lvl, // Analog output 2 level, 0.1 V units
    output reg [5:0] output_override_word_reg, // Stored override word
    output reg [3:0] bus_feedback_select_1_reg, // Stored selector 1
    output reg [31:0] bus_actual_1_reg, // Bus actual value 1
    output reg [31:0] bus_actual_2_reg, // Bus actual value 2
    output reg [31:0] bus_actual_3_reg, // Bus actual value 3
    output reg wr_reject_reg // Last write was refused, level
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pin synchroniser stages
    reg [11:0] din_meta_reg;
    reg [11:0] din_sync_reg;

    // Edited levels and levels shown
    reg [9:0] aout1_edit_reg;
    reg [9:0] aout2_edit_reg;
    reg [9:0] aout1_force_reg;
    reg [9:0] aout2_force_reg;

    // Selectors 2 and 3, setpoint function
    reg [3:0] bus_feedback_select_2_reg;
    reg [3:0] bus_feedback_select_3_reg;
    reg [2:0] setpt_func_reg;

    // Decoded enables, feedback helpers
    wire [3:0] relay_ext;
    wire [1:0] aout_ext;
    wire [15:0] dig_io_word;
    wire pos32;

    // Pins are asynchronous to clk, so two stages before any use
    // Inputs read 0 until two edges after reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            din_meta_reg <= 12'h000;
            din_sync_reg <= 12'h000;
        end else begin
            din_meta_reg <= digital_input;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // True when a function selection asks for external control
    // Any other code leaves the normal function
    function is_ext;
        input [2:0] func;
        begin
            is_ext = (func == `OOBF_FUNC_EXT_CTRL); // RL2
        end
    endfunction

    // Selector range check, shared by all three feedback selectors
    // Upper bits must be zero, so wide words cannot alias
    function sel_ok;
        input [31:0] data;
        begin
            sel_ok = (data[31:4] == 28'h000_0000) && (data[3:0] <= `OOBF_FB_SEL_MAX); // RL14
        end
    endfunction

    // Level range check for forced analog values
    // Steps of 0.1 V, so 100 is the 10.0 V ceiling
    function lvl_ok;
        input [31:0] data;
        begin
            lvl_ok = (data[31:10] == 22'h00_0000) && (data[9:0] <= `OOBF_AOUT_MAX); // RL6 RL14
        end
    endfunction

    // Multiplexer for the feedback value
    // Short quantities are zero-extended, not sign-extended
    // Codes 13 to 15 are refused; default keeps it total
    function [31:0] fb_mux;
        input [3:0] sel;
        input [15:0] dio;
        input use32;
        begin
            case (sel)
                // Codes 0 to 5: off, drive quantities and IO word
                `OOBF_SEL_OFF: fb_mux = 32'h0000_0000; // RL9
                `OOBF_SEL_OUT_FREQ: fb_mux = {16'h0000, q_out_freq};
                `OOBF_SEL_SPEED: fb_mux = {16'h0000, q_speed};
                `OOBF_SEL_CURRENT: fb_mux = {16'h0000, q_current};
                `OOBF_SEL_TORQUE_CUR: fb_mux = {16'h0000, q_torque_cur};
                `OOBF_SEL_DIG_IO: fb_mux = {16'h0000, dio};
                // Positions are 32 bits and pass whole
                `OOBF_SEL_POS_ACT: fb_mux = q_pos_act; // RL10
                `OOBF_SEL_POS_SET: fb_mux = q_pos_set;
                `OOBF_SEL_NOM_FREQ: fb_mux = {16'h0000, q_nom_freq};
                `OOBF_SEL_ERR_CODE: fb_mux = {16'h0000, q_err_code};
                // Increments already come in 8192 per rev units; width follows setpoint
                `OOBF_SEL_POS_INC_ACT: fb_mux = use32 ? q_pos_inc_act :
                    {16'h0000, q_pos_inc_act[15:0]}; // RL12 RL13
                `OOBF_SEL_POS_INC_SET: fb_mux = use32 ? q_pos_inc_set :
                    {16'h0000, q_pos_inc_set[15:0]}; // RL12 RL13
                `OOBF_SEL_BUS_OUT: fb_mux = {16'h0000, q_bus_out};
                default: fb_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Parameter storage
    // ------------------------------------------------------------
    // Any 6-bit override value is legal; wider data is refused
    // An accepted write clears the refusal flag
    // Limitation: the flag does not say which check failed
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            output_override_word_reg <= `OOBF_OVERRIDE_RST;
            bus_feedback_select_1_reg <= `OOBF_FB_SEL1_RST;
            bus_feedback_select_2_reg <= `OOBF_FB_SEL23_RST;
            bus_feedback_select_3_reg <= `OOBF_FB_SEL23_RST;
            aout1_edit_reg <= `OOBF_AOUT_RST;
            aout2_edit_reg <= `OOBF_AOUT_RST;
            setpt_func_reg <= `OOBF_SETPT_FUNC_RST;
            wr_reject_reg <= 1'b0;
        end else if (par_wr) begin
            // Only a write strobe touches stored values
            wr_reject_reg <= 1'b0;
            if (par_addr == `OOBF_ADDR_OVERRIDE) begin
                // Upper bits only; every 6-bit pattern is legal
                if (par_wdata[31:6] == 26'h000_0000)
                    output_override_word_reg <= par_wdata[5:0]; // RL3 RL5
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_AOUT1_LVL) begin
                // Edit value only; the output waits for a confirm
                if (lvl_ok(par_wdata))
                    aout1_edit_reg <= par_wdata[9:0];
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_AOUT2_LVL) begin
                if (lvl_ok(par_wdata))
                    aout2_edit_reg <= par_wdata[9:0];
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_FB_SEL1) begin
                // Served whatever the object type
                if (sel_ok(par_wdata))
                    bus_feedback_select_1_reg <= par_wdata[3:0]; // RL8
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_FB_SEL2) begin
                // Kept even while the larger types are off
                if (sel_ok(par_wdata))
                    bus_feedback_select_2_reg <= par_wdata[3:0]; // RL15
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_FB_SEL3) begin
                if (sel_ok(par_wdata))
                    bus_feedback_select_3_reg <= par_wdata[3:0]; // RL15
                else
                    wr_reject_reg <= 1'b1; // RL14
            end else if (par_addr == `OOBF_ADDR_SETPT_FUNC1) begin
                // Only its position width matters here
                if (par_wdata[31:3] == 29'h0000_0000)
                    setpt_func_reg <= par_wdata[2:0];
                else
                    wr_reject_reg <= 1'b1;
            end else begin
                // Unknown address: nothing is stored
                wr_reject_reg <= 1'b1;
            end
        end
    end

    // Edited analog levels take effect only on confirm, never mid-edit
    // One confirm commits both levels, the other edit too
    // Without a confirm the last committed level stays
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aout1_force_reg <= `OOBF_AOUT_RST;
            aout2_force_reg <= `OOBF_AOUT_RST;
        end else if (par_confirm) begin
            aout1_force_reg <= aout1_edit_reg; // RL7
            aout2_force_reg <= aout2_edit_reg; // RL7
        end
    end

    // ------------------------------------------------------------
    // Output override
    // ------------------------------------------------------------
    // Combinational from the stored word, so a write shows next cycle
    // Trade-off: no output flop, a function change acts at once
    assign relay_ext = {is_ext(func_relay4), is_ext(func_relay3),
                        is_ext(func_relay2), is_ext(func_relay1)};
    assign aout_ext = {is_ext(func_aout2) & aout2_dig_mode,
                       is_ext(func_aout1) & aout1_dig_mode};

    // Relays take bits 0, 1, 4 and 5 of the word
    assign relay_out[0] = relay_ext[0] ? output_override_word_reg[`OOBF_BIT_RELAY1] :
                          norm_relay[0]; // RL1 RL2 RL4
    assign relay_out[1] = relay_ext[1] ? output_override_word_reg[`OOBF_BIT_RELAY2] :
                          norm_relay[1]; // RL4
    assign relay_out[2] = relay_ext[2] ? output_override_word_reg[`OOBF_BIT_RELAY3] :
                          norm_relay[2]; // RL4
    assign relay_out[3] = relay_ext[3] ? output_override_word_reg[`OOBF_BIT_RELAY4] :
                          norm_relay[3]; // RL4

    // Analog outputs in digital use take bits 2 and 3
    assign aout_dig_out[0] = aout_ext[0] ? output_override_word_reg[`OOBF_BIT_AOUT1] :
                             norm_aout_dig[0]; // RL4
    assign aout_dig_out[1] = aout_ext[1] ? output_override_word_reg[`OOBF_BIT_AOUT2] :
                             norm_aout_dig[1]; // RL4

    // Analog level is forced only when the output is in external control
    // Digital mode plays no part in the level
    assign aout1_lvl = is_ext(func_aout1) ? aout1_force_reg : norm_aout1_lvl; // RL6
    assign aout2_lvl = is_ext(func_aout2) ? aout2_force_reg : norm_aout2_lvl; // RL6

    // ------------------------------------------------------------
    // Bus feedback
    // ------------------------------------------------------------
    // Relay bits report the driven state, override included
    assign dig_io_word = {relay_out, din_sync_reg}; // RL11

    // Setpoint codes 3 and 6 carry a 32-bit position
    assign pos32 = (setpt_func_reg == `OOBF_SETPT_POS32) ||
                   (setpt_func_reg == `OOBF_SETPT_POS32_INC); // RL13

    // Values 2 and 3 exist only with the larger data object types
    // All three are flops, so the bus reads one edge's values
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_actual_1_reg <= 32'h0000_0000;
            bus_actual_2_reg <= 32'h0000_0000;
            bus_actual_3_reg <= 32'h0000_0000;
        end else begin
            bus_actual_1_reg <= fb_mux(bus_feedback_select_1_reg, dig_io_word, pos32); // RL8
            // Same scheme, gated by the object type
            bus_actual_2_reg <= par_large_pdo ?
                fb_mux(bus_feedback_select_2_reg, dig_io_word, pos32) : 32'h0000_0000; // RL15
            bus_actual_3_reg <= par_large_pdo ?
                fb_mux(bus_feedback_select_3_reg, dig_io_word, pos32) : 32'h0000_0000; // RL15
        end
    end

endmodule // oobf_output_override_bus_feedback

// ---- oobf_chk.sv ----
// Checker for the output override and bus feedback register bank
`timescale 1ns/1ps
module oobf_chk (
    input wire clk, // System clock
    input wire rst_b, // Reset, active low
    input wire par_wr, // Write strobe
    input wire [3:0] par_addr, // Write address
    input wire [31:0] par_wdata, // Write data
    input wire par_confirm, // Level entry confirm
    input wire [2:0] func_relay1, // Relay 1 function
    input wire [2:0] func_relay2, // Relay 2 function
    input wire [2:0] func_aout1, // Analog 1 function
    input wire aout1_dig_mode, // Analog 1 used digitally
    input wire [3:0] norm_relay, // Normal relay states
    input wire [15:0] q_out_freq, // Output frequency
    input wire [31:0] q_pos_act, // Present position
    input wire [3:0] relay_out, // Relay drive
    input wire [9:0] aout1_lvl, // Analog 1 level
    input wire [5:0] output_override_word_reg, // Override word
    input wire [3:0] bus_feedback_select_1_reg, // Selector 1
    input wire [31:0] bus_actual_1_reg, // Actual value 1
    input wire wr_reject_reg // Refused write flag
);
    // ------------------------------------------------------------
    // Write, override and feedback relations
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ovr_store_a: assert property (par_wr && par_addr == 4'h0 && par_wdata <= 32'h0000_003f
        |=> output_override_word_reg == $past(par_wdata[5:0]) && !wr_reject_reg)
        else $error("override word not stored");
    ovr_refuse_a: assert property (par_wr && par_addr == 4'h0 && par_wdata > 32'h0000_003f
        |=> wr_reject_reg && $stable(output_override_word_reg))
        else $error("override refusal wrong");
    relay_force_a: assert property (func_relay1 == 3'h7
        |-> relay_out[0] == output_override_word_reg[0]) else $error("relay 1 not forced");
    relay_normal_a: assert property (func_relay2 != 3'h7
        |-> relay_out[1] == norm_relay[1]) else $error("relay 2 not normal");
    sel_store_a: assert property (par_wr && par_addr == 4'h3 && par_wdata <= 32'h0000_000c
        |=> bus_feedback_select_1_reg == $past(par_wdata[3:0])) else $error("selector not stored");
    sel_refuse_a: assert property (par_wr && par_addr == 4'h3 && par_wdata > 32'h0000_000c
        |=> $stable(bus_feedback_select_1_reg)) else $error("selector refusal wrong");
    fb_freq_a: assert property (bus_feedback_select_1_reg == 4'h1
        |=> bus_actual_1_reg[15:0] == $past(q_out_freq)) else $error("frequency feedback wrong");
    fb_position_a: assert property (bus_feedback_select_1_reg == 4'h6
        |=> bus_actual_1_reg == $past(q_pos_act)) else $error("position feedback wrong");
    fb_off_a: assert property (bus_feedback_select_1_reg == 4'h0
        |=> bus_actual_1_reg == 32'h0000_0000) else $error("off feedback not zero");
    lvl_hold_a: assert property (func_aout1 == 3'h7 && !aout1_dig_mode && $stable(func_aout1)
        && $stable(aout1_dig_mode) && !$past(par_confirm) |-> $stable(aout1_lvl))
        else $error("analog level moved without confirm");
endmodule // oobf_chk

bind oobf_output_override_bus_feedback oobf_chk chk_i (.*);

// ---- oobf_param_master.sv ----
// Parameter-writing master model for the override and feedback bank
`timescale 1ns/1ps
module oobf_param_master (
    input wire clk, // System clock
    output reg par_wr, // Write strobe
    output reg [3:0] par_addr, // Write address
    output reg [31:0] par_wdata, // Write data
    output reg par_confirm // Level entry confirm
);
    // Idle values at time zero
    initial begin
        par_wr = 1'b0;
        par_addr = 4'hf;
        par_wdata = 32'h0000_0000;
        par_confirm = 1'b0;
    end
    // One word per strobe; released lines show the inverse so stale data never looks valid
    task write(input [3:0] a, input [31:0] d);
        begin
            @(negedge clk);
            par_wr = 1'b1;
            par_addr = a;
            par_wdata = d;
            @(negedge clk);
            par_wr = 1'b0;
            par_addr = ~a;
            par_wdata = ~d;
        end
    endtask
    // Single-cycle confirm of edited analog levels
    task confirm;
        begin
            @(negedge clk);
            par_confirm = 1'b1;
            @(negedge clk);
            par_confirm = 1'b0;
        end
    endtask
endmodule // oobf_param_master

// ---- test_output_override_bus_feedback.sv ----
// Self-checking testbench for the override and bus feedback bank
`timescale 1ns/1ps
module test_output_override_bus_feedback;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg par_large_pdo = 1'b0;
    reg aout1_dig_mode = 1'b1;
    reg aout2_dig_mode = 1'b1;
    reg [2:0] func_relay1, func_relay2, func_relay3, func_relay4, func_aout1, func_aout2;
    reg [3:0] norm_relay;
    reg [1:0] norm_aout_dig;
    reg [9:0] norm_aout1_lvl, norm_aout2_lvl;
    reg [11:0] digital_input;
    reg [15:0] q_out_freq, q_speed, q_current, q_torque_cur, q_nom_freq, q_err_code, q_bus_out;
    reg [31:0] q_pos_act, q_pos_set, q_pos_inc_act, q_pos_inc_set;
    wire par_wr, par_confirm, wr_reject_reg;
    wire [3:0] par_addr, relay_out, bus_feedback_select_1_reg;
    wire [31:0] par_wdata, bus_actual_1_reg, bus_actual_2_reg, bus_actual_3_reg;
    wire [5:0] output_override_word_reg;
    wire [1:0] aout_dig_out;
    wire [9:0] aout1_lvl, aout2_lvl;
    integer seed, fails, checks, i;
    reg [127:0] rr;
    reg [5:0] ov;

    oobf_output_override_bus_feedback uut (.*);
    oobf_param_master m (.*);

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Expectations and reporting
    // ------------------------------------------------------------
    function [3:0] rel_exp(input [5:0] o);
        rel_exp = {func_relay4 == 3'h7 ? o[5] : norm_relay[3], func_relay3 == 3'h7 ? o[4] :
            norm_relay[2], func_relay2 == 3'h7 ? o[1] : norm_relay[1],
            func_relay1 == 3'h7 ? o[0] : norm_relay[0]};
    endfunction
    function [1:0] dig_exp(input [5:0] o);
        dig_exp = {func_aout2 == 3'h7 && aout2_dig_mode ? o[3] : norm_aout_dig[1],
            func_aout1 == 3'h7 && aout1_dig_mode ? o[2] : norm_aout_dig[0]};
    endfunction
    // Sixteen-bit quantities are kept below 0x8000 so sign handling cannot matter
    function [31:0] fb_exp(input [3:0] s, input w32);
        case (s)
            4'h1: fb_exp = {16'h0000, q_out_freq};
            4'h2: fb_exp = {16'h0000, q_speed};
            4'h3: fb_exp = {16'h0000, q_current};
            4'h4: fb_exp = {16'h0000, q_torque_cur};
            4'h5: fb_exp = {16'h0000, rel_exp(ov), digital_input};
            4'h6: fb_exp = q_pos_act;
            4'h7: fb_exp = q_pos_set;
            4'h8: fb_exp = {16'h0000, q_nom_freq};
            4'h9: fb_exp = {16'h0000, q_err_code};
            4'ha: fb_exp = w32 ? q_pos_inc_act : {16'h0000, q_pos_inc_act[15:0]};
            4'hb: fb_exp = w32 ? q_pos_inc_set : {16'h0000, q_pos_inc_set[15:0]};
            4'hc: fb_exp = {16'h0000, q_bus_out};
            default: fb_exp = 32'h0000_0000;
        endcase
    endfunction
    task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task rand_in;
        begin
            rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
            {q_pos_act, q_pos_set, q_pos_inc_act, q_pos_inc_set} = rr;
            rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
            {q_out_freq, q_speed, q_current, q_torque_cur, q_nom_freq, q_err_code, q_bus_out,
                digital_input, norm_relay} = rr & {{7{16'h7fff}}, 16'hffff};
            {norm_aout_dig, norm_aout1_lvl, norm_aout2_lvl} = rr[121:100];
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk);
        fails = fails + 1;
        $display("Error watchdog expired");
        end_sim;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h9a1f;
        fails = 0;
        checks = 0;
        ov = 6'h00;
        {func_aout2, func_aout1, func_relay4, func_relay3, func_relay2, func_relay1} = 18'h3_ffff;
        rand_in;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("override", 32'h0000_0000, output_override_word_reg);
        chk("select1", 32'h0000_0001, bus_feedback_select_1_reg);
        chk("reject", 32'h0000_0000, wr_reject_reg);
        // Override corners first, then random words, with mixed functions from the fifth word on
        for (i = 0; i < 16; i = i + 1) begin
            rand_in;
            ov = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : rr[5:0];
            if (i > 3) {func_aout2, func_aout1, func_relay4, func_relay3, func_relay2,
                func_relay1} = rr[35:18] | rr[53:36];
            m.write(4'h0, {26'h000_0000, ov});
            chk("override", ov, output_override_word_reg);
            chk("relay", rel_exp(ov), relay_out);
            chk("aout_dig", dig_exp(ov), aout_dig_out);
        end
        m.write(4'h0, 32'h0000_0040);
        chk("override", ov, output_override_word_reg);
        chk("reject", 32'h0000_0001, wr_reject_reg);
        // Every selector code, two sync cycles allowed for the inputs
        for (i = 0; i < 13; i = i + 1) begin
            m.write(4'h3, i);
            rand_in;
            repeat (4) @(negedge clk);
            chk("select1", i, bus_feedback_select_1_reg);
            chk("actual1", fb_exp(i[3:0], 1'b0), bus_actual_1_reg);
        end
        m.write(4'h3, 32'h0000_000d);
        chk("select1", 32'h0000_000c, bus_feedback_select_1_reg);
        // Increment width follows the setpoint function
        for (i = 0; i < 3; i = i + 1) begin
            m.write(4'h6, (i == 0) ? 32'h0000_0005 : (i == 1) ? 32'h0000_0003 : 32'h0000_0006);
            m.write(4'h3, 32'h0000_000a + i[0]);
            repeat (3) @(negedge clk);
            chk("actual1", fb_exp(4'ha + {3'h0, i[0]}, i != 0), bus_actual_1_reg);
        end
        m.write(4'h7, 32'h0000_0000);
        chk("reject", 32'h0000_0001, wr_reject_reg);
        m.write(4'h4, 32'h0000_0003);
        m.write(4'h5, 32'h0000_0006);
        repeat (3) @(negedge clk);
        chk("actual2", 32'h0000_0000, bus_actual_2_reg);
        par_large_pdo = 1'b1;
        repeat (3) @(negedge clk);
        chk("actual2", fb_exp(4'h3, 1'b1), bus_actual_2_reg);
        chk("actual3", fb_exp(4'h6, 1'b1), bus_actual_3_reg);
        // Forced analog level only moves on confirm; 101 is out of range
        {func_aout1, aout1_dig_mode, func_aout2} = {3'h7, 1'b0, 3'h7};
        m.write(4'h1, 32'h0000_0032);
        m.write(4'h2, 32'h0000_0019);
        repeat (2) @(negedge clk);
        chk("aout1", 32'h0000_0000, aout1_lvl);
        chk("aout2", 32'h0000_0000, aout2_lvl);
        for (i = 0; i < 3; i = i + 1) begin
            m.write(4'h1, (i == 0) ? 32'h0000_0065 : (i == 1) ? 32'h0000_0064 : 32'h0000_0000);
            m.confirm;
            chk("aout1", (i == 0) ? 32'h0000_0032 : (i == 1) ? 32'h0000_0064 : 32'h0000_0000,
                aout1_lvl);
        end
        chk("aout2", 32'h0000_0019, aout2_lvl);
        func_aout1 = 3'h2;
        @(negedge clk);
        chk("aout1", norm_aout1_lvl, aout1_lvl);
        end_sim;
    end
endmodule // test_output_override_bus_feedback
